/* verilog/display_ram_pkg.sv */
// display memory address logic: shared constants, command codes, map
// assumes one clock domain; host and device ends meet in display_link_if

package display_ram_pkg;

    // ------------------------------------------------------------------
    // memory shape
    // ------------------------------------------------------------------
    localparam int ROWS = 128;
    localparam int COLUMN_GROUPS = 32;
    localparam int SLICE_W = 256;
    localparam int PTR_W = 7;
    localparam logic [6:0] COLUMN_END = 7'h7F;
    localparam logic [6:0] MAX_COLUMN_VALUE = 7'h1F;

    // ------------------------------------------------------------------
    // address control and panel control field bits
    // ------------------------------------------------------------------
    localparam int ADDR_CTRL_WRAP = 0;
    localparam int ADDR_CTRL_DIR = 1;
    localparam int ADDR_CTRL_STEP = 2;
    localparam int ADDR_CTRL_WINDOW = 4;
    localparam int PANEL_ROW_MIRROR = 3;
    localparam logic [6:0] COM_END_RESET = 7'h7F;

    // ------------------------------------------------------------------
    // link commands
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        CMD_COL_PTR = 4'h0,
        CMD_ROW_PTR = 4'h1,
        CMD_ADDR_CTRL = 4'h2,
        CMD_COL_MIRROR = 4'h3,
        CMD_PANEL_CTRL = 4'h4,
        CMD_SCROLL = 4'h5,
        CMD_FIX_TOP = 4'h6,
        CMD_FIX_BOTTOM = 4'h7,
        CMD_COM_END = 4'h8,
        CMD_WIN_ROW_FIRST = 4'h9,
        CMD_WIN_ROW_LAST = 4'hA,
        CMD_WIN_COL_FIRST = 4'hB,
        CMD_WIN_COL_LAST = 4'hC
    } cmd_code_t;

    // ------------------------------------------------------------------
    // host register map (AXI4-Lite, byte addresses)
    // ------------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam logic [3:0] REG_CMD = 4'h0;
    localparam logic [3:0] REG_DATA = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;
    localparam int CMD_CODE_LSB = 8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : display_ram_pkg

/* verilog/display_link_if.sv */
// command and data link between host controller and display memory end
// assumes both ends on the same clock; strobes are one-cycle pulses

interface display_link_if;
    import display_ram_pkg::*;

    logic cmdValid;
    cmd_code_t cmdCode;
    logic [7:0] cmdValue;
    logic dataValid;
    logic [7:0] dataByte;

    modport host
    (
        output cmdValid,
        output cmdCode,
        output cmdValue,
        output dataValid,
        output dataByte
    );

    modport device
    (
        input cmdValid,
        input cmdCode,
        input cmdValue,
        input dataValid,
        input dataByte
    );

endinterface : display_link_if

/* verilog/display_ram_device.sv */
// display memory end: pointers, window writes and scan-line addressing
// assumes link strobes and scan ticks come from logic on clk
//
// Chosen here: the placing of the registers and the AXI4-Lite register port.

module display_ram_device
(
    input wire logic clk,
    input wire logic reset,
    display_link_if.device link,
    input wire logic fieldStart,
    input wire logic lineTick,
    output logic [display_ram_pkg::PTR_W-1:0] lineAddr,
    output logic [display_ram_pkg::SLICE_W-1:0] sliceData,
    output logic [display_ram_pkg::PTR_W-1:0] rowPointer,
    output logic [display_ram_pkg::PTR_W-1:0] columnGroupPointer
);
    import display_ram_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [6:0] colPtr;
        logic [6:0] rowPtr;
        logic [4:0] addressControlField;
        logic columnMirror;
        logic [3:0] panelControlField;
        logic [6:0] scrollStartLine;
        logic [6:0] fixedBandTop;
        logic [6:0] fixedBandBottom;
        logic [6:0] comEndValue;
        logic [6:0] windowRowFirst;
        logic [6:0] windowRowLast;
        logic [6:0] windowColFirst;
        logic [6:0] windowColLast;
        logic [6:0] comIndex;
        logic [6:0] lineAddr;
        logic [SLICE_W-1:0] slice;
    } dev_state_t;

    localparam dev_state_t DEV_RESET = '{
        comEndValue: COM_END_RESET,
        default: '0
    };

    dev_state_t st;
    dev_state_t nx;

    // one row per word; a host write touches one byte of one row
    logic [SLICE_W-1:0] mem [ROWS];

    logic [4:0] physCol;
    logic [6:0] colSel;
    logic [6:0] colNear;
    logic [6:0] colFar;
    logic colDown;
    logic rowDown;
    logic [6:0] rowNear;
    logic [6:0] rowFar;
    logic [6:0] scanIdx;
    logic windowOn;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [6:0] stepPtr(input logic [6:0] p,
                                           input logic down);
        return down ? p - 7'h01 : p + 7'h01;
    endfunction : stepPtr

    function automatic logic [6:0] colBound(input logic [6:0] b,
                                            input logic m);
        return m ? MAX_COLUMN_VALUE - b : b;
    endfunction : colBound

    // scan index counts commons in fixed order; only the address moves
    function automatic logic [6:0] lineFor(input logic [6:0] idx,
                                           input dev_state_t s);
        logic [6:0] rev;
        logic band;
        logic my;
        rev = s.comEndValue - idx;
        my = s.panelControlField[PANEL_ROW_MIRROR];
        band = ((s.fixedBandTop | s.fixedBandBottom) != 7'h00)
            && idx >= s.fixedBandTop && idx <= s.fixedBandBottom;
        if (band)
            return my ? rev : idx;
        // sums wrap in seven bits, which is the modulo 128 walk
        return my ? s.scrollStartLine + rev
                  : s.scrollStartLine + idx;
    endfunction : lineFor

    // ------------------------------------------------------------------
    // window geometry
    // ------------------------------------------------------------------
    always_comb
    begin
        windowOn = st.addressControlField[ADDR_CTRL_WINDOW];
        colNear = colBound(st.windowColFirst, st.columnMirror);
        colFar = colBound(st.windowColLast, st.columnMirror);
        colDown = colNear > colFar;
        rowDown = st.addressControlField[ADDR_CTRL_STEP];
        rowNear = rowDown ? st.windowRowLast : st.windowRowFirst;
        rowFar = rowDown ? st.windowRowFirst : st.windowRowLast;
        // window bounds are already reflected, so no second mirror
        colSel = windowOn ? st.colPtr
               : (st.columnMirror ? MAX_COLUMN_VALUE - st.colPtr
                                  : st.colPtr);
        physCol = colSel[4:0];
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb
    begin
        nx = st;
        scanIdx = 7'h00;

        // pointer advance after each data byte
        if (link.dataValid)
        begin
            if (windowOn)
            begin
                if (!st.addressControlField[ADDR_CTRL_WRAP])
                begin
                    if (st.colPtr != colFar)
                        nx.colPtr = stepPtr(st.colPtr, colDown);
                end
                else if (!st.addressControlField[ADDR_CTRL_DIR])
                begin
                    if (st.colPtr == colFar)
                    begin
                        nx.colPtr = colNear;
                        nx.rowPtr = (st.rowPtr == rowFar) ? rowNear
                                  : stepPtr(st.rowPtr, rowDown);
                    end
                    else
                        nx.colPtr = stepPtr(st.colPtr, colDown);
                end
                else if (st.rowPtr == rowFar)
                begin
                    nx.rowPtr = rowNear;
                    nx.colPtr = (st.colPtr == colFar) ? colNear
                              : stepPtr(st.colPtr, colDown);
                end
                else
                    nx.rowPtr = stepPtr(st.rowPtr, rowDown);
            end
            else if (st.colPtr != COLUMN_END)
                nx.colPtr = st.colPtr + 7'h01;
            else if (st.addressControlField[ADDR_CTRL_WRAP])
            begin
                nx.colPtr = 7'h00;
                // seven-bit step wraps 127 to 0 and 0 to 127
                nx.rowPtr = stepPtr(st.rowPtr, rowDown);
            end
            // otherwise parked at the row end until reloaded
        end

        // a pointer loaded by a command overrides its own advance in the same cycle
        if (link.cmdValid)
        begin
            unique case (link.cmdCode)
                CMD_COL_PTR: nx.colPtr = link.cmdValue[6:0];
                CMD_ROW_PTR: nx.rowPtr = link.cmdValue[6:0];
                CMD_ADDR_CTRL:
                begin
                    nx.addressControlField = link.cmdValue[4:0];
                    // arming the window parks the pointers at its corner
                    if (link.cmdValue[ADDR_CTRL_WINDOW] && !windowOn)
                    begin
                        nx.colPtr = colNear;
                        nx.rowPtr = link.cmdValue[ADDR_CTRL_STEP]
                                  ? st.windowRowLast
                                  : st.windowRowFirst;
                    end
                end
                // only the flag moves; memory is left as written
                CMD_COL_MIRROR: nx.columnMirror = link.cmdValue[0];
                CMD_PANEL_CTRL: nx.panelControlField = link.cmdValue[3:0];
                CMD_SCROLL: nx.scrollStartLine = link.cmdValue[6:0];
                CMD_FIX_TOP: nx.fixedBandTop = link.cmdValue[6:0];
                CMD_FIX_BOTTOM: nx.fixedBandBottom = link.cmdValue[6:0];
                CMD_COM_END: nx.comEndValue = link.cmdValue[6:0];
                CMD_WIN_ROW_FIRST: nx.windowRowFirst = link.cmdValue[6:0];
                CMD_WIN_ROW_LAST: nx.windowRowLast = link.cmdValue[6:0];
                CMD_WIN_COL_FIRST: nx.windowColFirst = link.cmdValue[6:0];
                CMD_WIN_COL_LAST: nx.windowColLast = link.cmdValue[6:0];
                default:
                begin
                end
            endcase
        end

        // scan side: one line per tick, field start restarts the count
        if (lineTick)
        begin
            scanIdx = (fieldStart || st.comIndex == st.comEndValue)
                    ? 7'h00 : st.comIndex + 7'h01;
            nx.comIndex = scanIdx;
            nx.lineAddr = lineFor(scanIdx, st);
            // read port sees the old byte if written in the same cycle
            nx.slice = mem[nx.lineAddr];
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
            st <= DEV_RESET;
        else
            st <= nx;
    end

    // memory contents are not cleared by reset
    always_ff @(posedge clk)
    begin
        if (link.dataValid)
            mem[st.rowPtr][{physCol, 3'b000} +: 8] <= link.dataByte;
    end

    assign lineAddr = st.lineAddr;
    assign sliceData = st.slice;
    assign rowPointer = st.rowPtr;
    assign columnGroupPointer = st.colPtr;

endmodule : display_ram_device

/* verilog/display_ram_host.sv */
// host end: AXI4-Lite slave that turns register writes into link traffic
// assumes one clock; the device end takes every link strobe at once

module display_ram_host
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [display_ram_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [display_ram_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    display_link_if.host link
);
    import display_ram_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        H_IDLE = 2'b01,
        H_SEND = 2'b10
    } host_state_t;

    typedef struct packed {
        host_state_t state;
        logic awready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic cmdValid;
        cmd_code_t cmdCode;
        logic [7:0] cmdValue;
        logic dataValid;
        logic [7:0] dataByte;
        logic [4:0] shadowCtrl;
        cmd_code_t pendCode;
        logic [7:0] pendValue;
    } host_reg_t;

    localparam host_reg_t HOST_RESET = '{
        state: H_IDLE,
        cmdCode: CMD_COL_PTR,
        pendCode: CMD_COL_PTR,
        default: '0
    };

    host_reg_t st;
    host_reg_t nx;
    cmd_code_t code;
    logic isBound;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb
    begin
        nx = st;
        nx.awready = 1'b0;
        nx.arready = 1'b0;
        nx.cmdValid = 1'b0;
        nx.dataValid = 1'b0;
        code = cmd_code_t'(wdata[CMD_CODE_LSB +: 4]);
        isBound = code == CMD_WIN_ROW_FIRST || code == CMD_WIN_ROW_LAST
               || code == CMD_WIN_COL_FIRST || code == CMD_WIN_COL_LAST;

        if (st.bvalid && bready)
            nx.bvalid = 1'b0;
        if (st.rvalid && rready)
            nx.rvalid = 1'b0;

        // second half of a bound change made while the window was armed
        if (st.state == H_SEND)
        begin
            nx.cmdValid = 1'b1;
            nx.cmdCode = st.pendCode;
            nx.cmdValue = st.pendValue;
            nx.state = H_IDLE;
        end

        // address and data are taken together, one write at a time
        if (awvalid && wvalid && !st.awready && !st.bvalid
            && st.state == H_IDLE)
            nx.awready = 1'b1;

        if (st.awready && awvalid)
        begin
            nx.bvalid = 1'b1;
            nx.bresp = RESP_OKAY;
            unique case (awaddr)
                REG_CMD:
                begin
                    if (wstrb[0] && wstrb[1] && isBound
                        && st.shadowCtrl[ADDR_CTRL_WINDOW])
                    begin
                        // drop window enable before moving a bound
                        nx.cmdValid = 1'b1;
                        nx.cmdCode = CMD_ADDR_CTRL;
                        nx.cmdValue = {3'h0, st.shadowCtrl & 5'h0F};
                        nx.shadowCtrl[ADDR_CTRL_WINDOW] = 1'b0;
                        nx.pendCode = code;
                        nx.pendValue = wdata[7:0];
                        nx.state = H_SEND;
                    end
                    else if (wstrb[0] && wstrb[1])
                    begin
                        // mirror and pointer orders pass unchanged; software
                        // rewrites the memory after a mirror change
                        nx.cmdValid = 1'b1;
                        nx.cmdCode = code;
                        nx.cmdValue = wdata[7:0];
                        if (code == CMD_ADDR_CTRL)
                            nx.shadowCtrl = wdata[4:0];
                    end
                end
                REG_DATA:
                begin
                    nx.dataValid = wstrb[0];
                    nx.dataByte = wdata[7:0];
                end
                default: nx.bresp = RESP_SLVERR;
            endcase
        end

        if (arvalid && !st.arready && !st.rvalid)
            nx.arready = 1'b1;

        if (st.arready && arvalid)
        begin
            nx.rvalid = 1'b1;
            nx.rresp = RESP_OKAY;
            nx.rdata = 32'h0;
            unique case (araddr)
                REG_STATUS:
                    nx.rdata = {26'h0, st.state == H_SEND, st.shadowCtrl};
                REG_CMD, REG_DATA:
                begin
                end
                default: nx.rresp = RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            st <= HOST_RESET;
        else
            st <= nx;
    end

    assign awready = st.awready;
    assign wready = st.awready;
    assign bvalid = st.bvalid;
    assign bresp = st.bresp;
    assign arready = st.arready;
    assign rvalid = st.rvalid;
    assign rresp = st.rresp;
    assign rdata = st.rdata;
    assign link.cmdValid = st.cmdValid;
    assign link.cmdCode = st.cmdCode;
    assign link.cmdValue = st.cmdValue;
    assign link.dataValid = st.dataValid;
    assign link.dataByte = st.dataByte;

endmodule : display_ram_host

/* bench/display_ram_checker.sv */
// checker: pointer stepping on the link and the scan-line address order
// assumes one clock and synchronous reset

module display_ram_checker
(
    input wire logic clk,
    input wire logic reset,
    input wire logic cmdValid,
    input wire display_ram_pkg::cmd_code_t cmdCode,
    input wire logic [7:0] cmdValue,
    input wire logic dataValid,
    input wire logic lineTick,
    input wire logic fieldStart,
    input wire logic [6:0] lineAddr,
    input wire logic [6:0] rowPointer,
    input wire logic [6:0] columnGroupPointer
);
    timeunit 1ns;
    timeprecision 1ps;
    import display_ram_pkg::*;

    logic [4:0] ctrl_reg;
    logic mirror_reg;
    logic [6:0] scroll_reg, comEnd_reg, top_reg, bottom_reg, idx_reg;
    logic [6:0] idx_next, line_next;
    logic band;

    always_comb
    begin
        idx_next = idx_reg + 7'h01;
        if (fieldStart || idx_reg == comEnd_reg)
            idx_next = 7'h00;
        band = (top_reg | bottom_reg) != 7'h00 && idx_next >= top_reg
            && idx_next <= bottom_reg;
        if (band)
            line_next = mirror_reg ? comEnd_reg - idx_next : idx_next;
        else if (mirror_reg)
            line_next = scroll_reg + comEnd_reg - idx_next;
        else
            line_next = scroll_reg + idx_next;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            {ctrl_reg, mirror_reg, scroll_reg, top_reg} <= '0;
            {bottom_reg, idx_reg} <= '0;
            comEnd_reg <= COM_END_RESET;
        end
        else
        begin
            if (lineTick)
                idx_reg <= idx_next;
            if (cmdValid)
            begin
                case (cmdCode)
                    CMD_ADDR_CTRL: ctrl_reg <= cmdValue[4:0];
                    CMD_PANEL_CTRL: mirror_reg <= cmdValue[PANEL_ROW_MIRROR];
                    CMD_SCROLL: scroll_reg <= cmdValue[6:0];
                    CMD_FIX_TOP: top_reg <= cmdValue[6:0];
                    CMD_FIX_BOTTOM: bottom_reg <= cmdValue[6:0];
                    CMD_COM_END: comEnd_reg <= cmdValue[6:0];
                    default: ;
                endcase
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    col_load_a:
        assert property (cmdValid && cmdCode == CMD_COL_PTR
            |=> columnGroupPointer == $past(cmdValue[6:0]))
        else $error("column load");
    row_load_a:
        assert property (cmdValid && cmdCode == CMD_ROW_PTR
            |=> rowPointer == $past(cmdValue[6:0]))
        else $error("row load");
    byte_step_a:
        assert property (dataValid && !cmdValid && !ctrl_reg[4]
            && columnGroupPointer != COLUMN_END |=> $stable(rowPointer)
            && columnGroupPointer == $past(columnGroupPointer) + 7'h01)
        else $error("column step");
    end_stop_a:
        assert property (dataValid && !cmdValid && ctrl_reg[4:0] == 5'h00
            && columnGroupPointer == COLUMN_END
            |=> columnGroupPointer == COLUMN_END && $stable(rowPointer))
        else $error("end stop");
    end_wrap_a:
        assert property (dataValid && !cmdValid && ctrl_reg[0] && !ctrl_reg[4]
            && columnGroupPointer == COLUMN_END |=> columnGroupPointer == 7'h00
            && rowPointer == $past(rowPointer) + (ctrl_reg[2] ? 7'h7F : 7'h01))
        else $error("end wrap");
    data_pulse_a:
        assert property (dataValid |=> !dataValid)
        else $error("data pulse");
    scan_plain_a:
        assert property (lineTick && !mirror_reg
            |=> lineAddr == $past(line_next))
        else $error("scan line");
    scan_mirror_a:
        assert property (lineTick && mirror_reg
            |=> lineAddr == $past(line_next))
        else $error("mirrored scan");
    scan_hold_a:
        assert property (!lineTick |=> $stable(lineAddr))
        else $error("line hold");

    cover property (dataValid && ctrl_reg[0]
        && columnGroupPointer == COLUMN_END);
    cover property (lineTick && mirror_reg);
    cover property (cmdValid && cmdCode == CMD_ADDR_CTRL && cmdValue[4]);

endmodule : display_ram_checker

/* bench/display_ram_address_generator_tb_top.sv */
// bench: AXI4-Lite writes through the host end, scan reads at the device
// assumes one clk; every memory row read back was written

module display_ram_address_generator_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import display_ram_pkg::*;

    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, rs = 32'h10;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
    logic rready = 1'b0, lineTick = 1'b0, fieldStart = 1'b0, tickD = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [6:0] lineAddr, rowPointer, columnGroupPointer;
    logic [255:0] sliceData;
    logic [7:0] mem [128][32];
    logic [1:0] bq[$];
    logic [33:0] rq[$];
    logic [262:0] sq[$];
    int fails = 0, num_checks = 0, cycles = 0;

    always #5 clk = ~clk;

    display_link_if link();
    display_ram_host u_display_ram_host (.clk, .reset, .awaddr, .awvalid,
        .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
        .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .link);
    display_ram_device u_display_ram_device (.clk, .reset, .link,
        .fieldStart, .lineTick, .lineAddr, .sliceData, .rowPointer,
        .columnGroupPointer);
    display_ram_checker u_display_ram_checker (.clk, .reset,
        .cmdValid(link.cmdValid), .cmdCode(link.cmdCode),
        .cmdValue(link.cmdValue), .dataValid(link.dataValid), .lineTick,
        .fieldStart, .lineAddr, .rowPointer, .columnGroupPointer);

    task results();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : results

    task miss(input string m);
        fails++;
        $display("CHECK FAILED %0t %s", $time, m);
    endtask : miss

    task chkResp(input logic [1:0] e, a);
        num_checks++;
        if (e !== a) miss("bresp");
    endtask : chkResp

    task chkRead(input logic [33:0] e, a);
        num_checks++;
        if (e !== a) miss("read");
    endtask : chkRead

    task chkSlice(input logic [262:0] e, a);
        num_checks++;
        if (e !== a) miss("slice");
    endtask : chkSlice

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miss("timeout");
            results();
        end
        tickD <= lineTick;
        if (bvalid && bready) chkResp(bq.pop_front(), bresp);
        if (rvalid && rready) chkRead(rq.pop_front(), {rresp, rdata});
        if (tickD) chkSlice(sq.pop_front(), {lineAddr, sliceData});
    end

    function logic [7:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs[7:0];
    endfunction : rnd

    task axiWrite(input logic [3:0] a, input logic [31:0] d,
        input logic [3:0] s, input logic [1:0] e);
        bq.push_back(e);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do @(posedge clk); while ((awready && wready) !== 1'b1);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do @(posedge clk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        @(posedge clk);
    endtask : axiWrite

    task axiRead(input logic [3:0] a, input logic [31:0] d,
        input logic [1:0] e);
        rq.push_back({e, d});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        @(posedge clk);
    endtask : axiRead

    task cmd(input cmd_code_t c, input logic [7:0] v);
        axiWrite(REG_CMD, {20'h00000, c, v}, 4'hF, RESP_OKAY);
    endtask : cmd

    task pix(input logic [6:0] r, input logic [4:0] g, input logic [7:0] b);
        mem[r][g] = b;
        axiWrite(REG_DATA, {24'h000000, b}, 4'h1, RESP_OKAY);
    endtask : pix

    task scan(input int n, input logic [6:0] s, c, input logic m,
        input logic [6:0] t, b);
        logic [6:0] i, ln;
        logic [255:0] sl;
        cmd(CMD_SCROLL, {1'b0, s});
        cmd(CMD_COM_END, {1'b0, c});
        cmd(CMD_PANEL_CTRL, {4'h0, m, 3'h0});
        cmd(CMD_FIX_TOP, {1'b0, t});
        cmd(CMD_FIX_BOTTOM, {1'b0, b});
        i = 7'h00;
        for (int k = 0; k < n; k++)
        begin
            ln = ((t | b) != 7'h00 && i >= t && i <= b) ? (m ? c - i : i)
                : (m ? s + c - i : s + i);
            for (int g = 0; g < 32; g++)
                sl[8*g+:8] = mem[ln][g];
            sq.push_back({ln, sl});
            lineTick <= 1'b1;
            fieldStart <= (k == 0);
            @(posedge clk);
            i = (i == c) ? 7'h00 : i + 7'h01;
        end
        lineTick <= 1'b0;
        fieldStart <= 1'b0;
    endtask : scan

    initial
    begin
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        cmd(CMD_ADDR_CTRL, 8'h01);
        cmd(CMD_ROW_PTR, 8'h7E);
        cmd(CMD_COL_PTR, 8'h00);
        for (int k = 0; k < 768; k++)
            pix(7'(126 + k / 128), 5'(k), rnd());
        cmd(CMD_ADDR_CTRL, 8'h00);
        cmd(CMD_ROW_PTR, 8'h00);
        cmd(CMD_COL_PTR, 8'h7E);
        pix(7'h00, 5'h1E, rnd());
        pix(7'h00, 5'h1F, rnd());
        pix(7'h00, 5'h1F, rnd());
        cmd(CMD_ADDR_CTRL, 8'h05);
        pix(7'h00, 5'h1F, rnd());
        pix(7'h7F, 5'h00, rnd());
        scan(6, 7'h7E, 7'h03, 1'b0, 7'h00, 7'h00);
        scan(5, 7'h7E, 7'h03, 1'b1, 7'h00, 7'h00);
        scan(4, 7'h7E, 7'h03, 1'b0, 7'h00, 7'h01);
        cmd(CMD_COL_MIRROR, 8'h01);
        cmd(CMD_ROW_PTR, 8'h01);
        cmd(CMD_COL_PTR, 8'h00);
        pix(7'h01, 5'h1F, rnd());
        cmd(CMD_COL_MIRROR, 8'h00);
        scan(2, 7'h00, 7'h01, 1'b0, 7'h00, 7'h00);
        cmd(CMD_WIN_ROW_FIRST, 8'h02);
        cmd(CMD_WIN_ROW_LAST, 8'h03);
        cmd(CMD_WIN_COL_FIRST, 8'h04);
        cmd(CMD_WIN_COL_LAST, 8'h05);
        cmd(CMD_ADDR_CTRL, 8'h15);
        axiRead(REG_STATUS, 32'h00000015, RESP_OKAY);
        pix(7'h03, 5'h04, rnd());
        pix(7'h03, 5'h05, rnd());
        pix(7'h02, 5'h04, rnd());
        pix(7'h02, 5'h05, rnd());
        pix(7'h03, 5'h04, rnd());
        cmd(CMD_WIN_COL_FIRST, 8'h04);
        axiRead(REG_STATUS, 32'h00000005, RESP_OKAY);
        cmd(CMD_ADDR_CTRL, 8'h13);
        pix(7'h02, 5'h04, rnd());
        pix(7'h03, 5'h04, rnd());
        pix(7'h02, 5'h05, rnd());
        scan(2, 7'h02, 7'h01, 1'b0, 7'h00, 7'h00);
        axiRead(4'hC, 32'h00000000, RESP_SLVERR);
        axiRead(REG_CMD, 32'h00000000, RESP_OKAY);
        axiWrite(4'hC, 32'h00000001, 4'hF, RESP_SLVERR);
        axiWrite(REG_STATUS, 32'h00000001, 4'hF, RESP_SLVERR);
        repeat (4) @(posedge clk);
        results();
    end

endmodule : display_ram_address_generator_tb_top
